//--- hdl/tcs_pkg.sv
// Shared constants of the ten-channel switch control block.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register slave.

package tcs_pkg;

	// ******************************************************************
	// Sizes
	// ******************************************************************
	localparam int NCH        = 10;
	localparam int FRAME_BITS = 16;
	localparam int CMD_W      = 4;
	localparam int DSEL_W     = 3;
	localparam int BCNT_W     = 5;
	localparam int CNT_W      = 9;
	localparam int ADDR_W     = 8;
	localparam int IRQ_W      = 6;
	localparam int SYNC_W     = 7 * NCH + 5;

	// ******************************************************************
	// Timing
	// ******************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int OVL_SLOW_NS   = 2000;
	localparam int OVL_FAST_NS   = 200;
	localparam logic [CNT_W-1:0] OVL_SLOW_CYC = CNT_W'(OVL_SLOW_NS * 1000 / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] OVL_FAST_CYC = CNT_W'(OVL_FAST_NS * 1000 / CLK_PERIOD_PS);

	// ******************************************************************
	// Serial frame: command in the top nibble, argument in the low bits
	// ******************************************************************
	localparam int CMD_LSB = FRAME_BITS - CMD_W;
	localparam logic [CMD_W-1:0] CMD_NOP       = 4'h0;
	localparam logic [CMD_W-1:0] CMD_SET_OUT   = 4'h1;
	localparam logic [CMD_W-1:0] CMD_SET_SRC   = 4'h2;
	localparam logic [CMD_W-1:0] CMD_CLEAR     = 4'h3;
	localparam logic [CMD_W-1:0] CMD_READ_DIAG = 4'h4;
	localparam logic [BCNT_W-1:0] FRAME_CNT    = 5'h10;

	// Diagnosis flag groups
	localparam logic [DSEL_W-1:0] DSEL_OVL  = 3'h0;
	localparam logic [DSEL_W-1:0] DSEL_OTMP = 3'h1;
	localparam logic [DSEL_W-1:0] DSEL_OPEN = 3'h2;
	localparam logic [DSEL_W-1:0] DSEL_SGND = 3'h3;
	localparam logic [DSEL_W-1:0] DSEL_SBAT = 3'h4;

	// ******************************************************************
	// Register map (byte addresses)
	// ******************************************************************
	localparam logic [ADDR_W-1:0] REG_SRC      = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SER_OUT  = 8'h04;
	localparam logic [ADDR_W-1:0] REG_FLT_OVL  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_FLT_OTMP = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_FLT_OPEN = 8'h10;
	localparam logic [ADDR_W-1:0] REG_FLT_SGND = 8'h14;
	localparam logic [ADDR_W-1:0] REG_FLT_SBAT = 8'h18;
	localparam logic [ADDR_W-1:0] REG_FLT_CLR  = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h24;
	localparam logic [ADDR_W-1:0] REG_STATE    = 8'h28;
	localparam int STATE_EN_BIT = 16;

	// Interrupt status bits
	localparam int IRQ_OVL   = 0;
	localparam int IRQ_OTMP  = 1;
	localparam int IRQ_OPEN  = 2;
	localparam int IRQ_SGND  = 3;
	localparam int IRQ_SBAT  = 4;
	localparam int IRQ_FRAME = 5;

endpackage

//--- hdl/tcs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes every bit is an independent level; no bus coherency is kept.

`timescale 1ns/1ps

module tcs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tcs_sync_t;

	tcs_sync_t s;
	tcs_sync_t next_s;

	always_comb begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
		if (rst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	assign q = s.s2;

endmodule

//--- hdl/tcs_top.sv
// Control and protection logic of a ten-channel low-side switch.
// Assumes asynchronous pins on the serial port, parallel inputs and
// fault detectors; registers reached over Avalon-MM with waitrequest.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.

`timescale 1ns/1ps

module tcs_top
	import tcs_pkg::*;
#(
	parameter logic [CNT_W-1:0] SLOW_CYC = OVL_SLOW_CYC,
	parameter logic [CNT_W-1:0] FAST_CYC = OVL_FAST_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Device pins
	input  wire logic              dev_rst_n,
	input  wire logic              en,
	input  wire logic [NCH-1:0]    par_in,
	// Serial port
	input  wire logic              spi_sclk,
	input  wire logic              spi_cs_n,
	input  wire logic              spi_si,
	output logic                   spi_so,
	output logic                   spi_so_oe_n,
	// Fault detectors
	input  wire logic [NCH-1:0]    det_ovc_low,
	input  wire logic [NCH-1:0]    det_ovc_high,
	input  wire logic [NCH-1:0]    det_otmp,
	input  wire logic [NCH-1:0]    det_open,
	input  wire logic [NCH-1:0]    det_sgnd,
	input  wire logic [NCH-1:0]    det_sbat,
	// Power stages
	output logic      [NCH-1:0]    stage_on,
	// Register bus
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Interrupt
	output logic                   irq
);

	// ******************************************************************
	// State
	// ******************************************************************
	typedef struct packed {
		logic [NCH-1:0]            src_ser;
		logic [NCH-1:0]            ser_out;
		logic [NCH-1:0]            f_ovl;
		logic [NCH-1:0]            f_otmp;
		logic [NCH-1:0]            f_open;
		logic [NCH-1:0]            f_sgnd;
		logic [NCH-1:0]            f_sbat;
		logic [NCH-1:0][CNT_W-1:0] ovl_cnt;
		logic [NCH-1:0]            gate;
		logic [FRAME_BITS-1:0]     sh;
		logic                      si_bit;
		logic [BCNT_W-1:0]         bit_cnt;
		logic                      cs_idle;
		logic                      sclk_q;
		logic                      cs_q;
		logic [DSEL_W-1:0]         rd_sel;
		logic                      rd_pend;
		logic [IRQ_W-1:0]          irq_stat;
		logic [IRQ_W-1:0]          irq_mask;
		logic                      irq;
		logic                      wait_req;
		logic [31:0]               rdata;
	} tcs_state_t;

	tcs_state_t s;
	tcs_state_t next_s;

	// ******************************************************************
	// Pin synchronisation
	// ******************************************************************
	logic [SYNC_W-1:0] sync_q;
	logic [NCH-1:0]    par_s;
	logic [NCH-1:0]    lo_s;
	logic [NCH-1:0]    hi_s;
	logic [NCH-1:0]    ot_s;
	logic [NCH-1:0]    op_s;
	logic [NCH-1:0]    sg_s;
	logic [NCH-1:0]    sb_s;
	logic              en_s;
	logic              rst_n_s;
	logic              sclk_s;
	logic              cs_n_s;
	logic              si_s;
	logic              dev_rst;

	tcs_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({det_sbat, det_sgnd, det_open, det_otmp, det_ovc_high, det_ovc_low,
		       par_in, en, dev_rst_n, spi_sclk, spi_cs_n, spi_si}),
		.q   (sync_q)
	);

	assign {sb_s, sg_s, op_s, ot_s, hi_s, lo_s, par_s, en_s, rst_n_s, sclk_s, cs_n_s, si_s}
		= sync_q;

	// Pin reset acts like the system reset on every flop except those of the synchroniser
	assign dev_rst = rst | ~rst_n_s;

	// ******************************************************************
	// Helpers
	// ******************************************************************
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [NCH-1:0] diag_pick(input logic [DSEL_W-1:0] sel,
		input tcs_state_t st);
		logic [NCH-1:0] r;
		r = '0;
		if (sel == DSEL_OVL) begin
			r = st.f_ovl;
		end else if (sel == DSEL_OTMP) begin
			r = st.f_otmp;
		end else if (sel == DSEL_OPEN) begin
			r = st.f_open;
		end else if (sel == DSEL_SGND) begin
			r = st.f_sgnd;
		end else if (sel == DSEL_SBAT) begin
			r = st.f_sbat;
		end
		return r;
	endfunction

	function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input tcs_state_t st,
		input logic en_lvl);
		logic [31:0] r;
		r = '0;
		if (a == REG_SRC) begin
			r[NCH-1:0] = st.src_ser;
		end else if (a == REG_SER_OUT) begin
			r[NCH-1:0] = st.ser_out;
		end else if (a == REG_FLT_OVL) begin
			r[NCH-1:0] = st.f_ovl;
		end else if (a == REG_FLT_OTMP) begin
			r[NCH-1:0] = st.f_otmp;
		end else if (a == REG_FLT_OPEN) begin
			r[NCH-1:0] = st.f_open;
		end else if (a == REG_FLT_SGND) begin
			r[NCH-1:0] = st.f_sgnd;
		end else if (a == REG_FLT_SBAT) begin
			r[NCH-1:0] = st.f_sbat;
		end else if (a == REG_IRQ_STAT) begin
			r[IRQ_W-1:0] = st.irq_stat;
		end else if (a == REG_IRQ_MASK) begin
			r[IRQ_W-1:0] = st.irq_mask;
		end else if (a == REG_STATE) begin
			r[NCH-1:0]      = st.gate;
			r[STATE_EN_BIT] = en_lvl;
		end
		return r;
	endfunction

	// ******************************************************************
	// Serial edges
	// ******************************************************************
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic frame_ok;

	assign sclk_rise = sclk_s & ~s.sclk_q;
	assign sclk_fall = ~sclk_s & s.sclk_q;
	assign cs_fall   = ~cs_n_s & s.cs_q;
	assign cs_rise   = cs_n_s & ~s.cs_q;
	assign frame_ok  = cs_rise & (s.bit_cnt == FRAME_CNT);

	// ******************************************************************
	// Next state
	// ******************************************************************
	always_comb begin
		logic [31:0]    wm;
		logic [31:0]    wz;
		logic [NCH-1:0] clr;
		logic [NCH-1:0] ovl_set;
		logic [NCH-1:0] req;
		logic [IRQ_W-1:0] ev;
		logic [CNT_W-1:0] c;
		logic [CMD_W-1:0] cmd;
		wm      = '0;
		wz      = '0;
		clr     = '0;
		ovl_set = '0;
		req     = '0;
		ev      = '0;
		c       = '0;
		cmd     = s.sh[FRAME_BITS-1:CMD_LSB];

		next_s        = s;
		next_s.sclk_q = sclk_s;
		next_s.cs_q   = cs_n_s;

		// Bus slave: one wait cycle, read data captured as waitrequest drops
		next_s.wait_req = 1'b1;
		if ((avs_read || avs_write) && s.wait_req) begin
			next_s.wait_req = 1'b0;
			next_s.rdata    = rd_word(avs_address, s, en_s);
		end
		wm = wmerge(rd_word(avs_address, s, en_s), avs_writedata, avs_byteenable);
		wz = wmerge('0, avs_writedata, avs_byteenable);
		if (avs_write && !s.wait_req) begin
			if (avs_address == REG_SRC) begin
				next_s.src_ser = wm[NCH-1:0];
			end else if (avs_address == REG_SER_OUT) begin
				next_s.ser_out = wm[NCH-1:0];
			end else if (avs_address == REG_FLT_CLR) begin
				clr = wz[NCH-1:0];
			end else if (avs_address == REG_IRQ_MASK) begin
				next_s.irq_mask = wm[IRQ_W-1:0];
			end
		end

		// Serial slave: sample on rising, shift on falling, SO from the top bit
		if (cs_fall) begin
			next_s.sh      = s.rd_pend
				? {s.rd_sel, {(FRAME_BITS-DSEL_W-NCH){1'b0}}, diag_pick(s.rd_sel, s)}
				: {{(FRAME_BITS-NCH){1'b0}}, s.f_ovl | s.f_otmp};
			next_s.rd_pend = 1'b0;
			next_s.bit_cnt = '0;
			next_s.cs_idle = 1'b0;
		end else if (!cs_n_s) begin
			if (sclk_rise) begin
				next_s.si_bit = si_s;
				if (s.bit_cnt != FRAME_CNT) begin
					next_s.bit_cnt = s.bit_cnt + 1'b1;
				end
			end
			if (sclk_fall && s.bit_cnt != '0) begin
				next_s.sh = {s.sh[FRAME_BITS-2:0], s.si_bit};
			end
		end
		if (cs_rise) begin
			next_s.cs_idle = 1'b1;
		end
		// Only the last sixteen bits count, so longer chains pass through
		if (frame_ok) begin
			ev[IRQ_FRAME] = 1'b1;
			if (cmd == CMD_SET_OUT) begin
				next_s.ser_out = s.sh[NCH-1:0];
			end else if (cmd == CMD_SET_SRC) begin
				next_s.src_ser = s.sh[NCH-1:0];
			end else if (cmd == CMD_CLEAR) begin
				clr = clr | s.sh[NCH-1:0];
			end else if (cmd == CMD_READ_DIAG) begin
				next_s.rd_sel  = s.sh[DSEL_W-1:0];
				next_s.rd_pend = 1'b1;
			end
		end

		// Overload filter: high threshold counts to the shorter limit
		for (int i = 0; i < NCH; i++) begin
			c = s.ovl_cnt[i];
			if (s.gate[i] && (hi_s[i] || lo_s[i])) begin
				next_s.ovl_cnt[i] = c + 1'b1;
				if ((hi_s[i] && c >= FAST_CYC - 1'b1) || c >= SLOW_CYC - 1'b1) begin
					ovl_set[i]        = 1'b1;
					next_s.ovl_cnt[i] = '0;
				end
			end else begin
				next_s.ovl_cnt[i] = '0;
			end
		end

		// Latched flags: a new fault wins over a clear in the same cycle
		next_s.f_ovl  = (s.f_ovl & ~clr) | ovl_set;
		next_s.f_otmp = (s.f_otmp & ~clr) | ot_s;
		next_s.f_open = (s.f_open & ~clr) | op_s;
		next_s.f_sgnd = (s.f_sgnd & ~clr) | sg_s;
		next_s.f_sbat = (s.f_sbat & ~clr) | sb_s;

		// Parallel pin n feeds channel n unless serial control is chosen
		req         = (s.src_ser & s.ser_out) | (~s.src_ser & par_s);
		next_s.gate = {NCH{en_s}} & req & ~next_s.f_ovl & ~next_s.f_otmp;

		ev[IRQ_OVL]  = |(ovl_set & ~s.f_ovl);
		ev[IRQ_OTMP] = |(ot_s & ~s.f_otmp);
		ev[IRQ_OPEN] = |(op_s & ~s.f_open);
		ev[IRQ_SGND] = |(sg_s & ~s.f_sgnd);
		ev[IRQ_SBAT] = |(sb_s & ~s.f_sbat);
		if (avs_write && !s.wait_req && avs_address == REG_IRQ_STAT) begin
			next_s.irq_stat = (s.irq_stat & ~wz[IRQ_W-1:0]) | ev;
		end else begin
			next_s.irq_stat = s.irq_stat | ev;
		end
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

		if (dev_rst) begin
			next_s          = '0;
			next_s.wait_req = 1'b1;
			next_s.cs_idle  = 1'b1;
			next_s.cs_q     = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	assign stage_on        = s.gate;
	assign spi_so          = s.sh[FRAME_BITS-1];
	assign spi_so_oe_n     = s.cs_idle;
	assign avs_readdata    = s.rdata;
	assign avs_waitrequest = s.wait_req;
	assign irq             = s.irq;

	// ******************************************************************
	// Assertions
	// ******************************************************************
	// Channels whose overload counter sits one step before a trip
	logic [NCH-1:0] at_fast;
	logic [NCH-1:0] at_slow;

	always_comb begin
		at_fast = '0;
		at_slow = '0;
		for (int i = 0; i < NCH; i++) begin
			at_fast[i] = s.gate[i] && hi_s[i] && (s.ovl_cnt[i] == FAST_CYC - 1'b1);
			at_slow[i] = s.gate[i] && lo_s[i] && !hi_s[i] && (s.ovl_cnt[i] == SLOW_CYC - 1'b1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (dev_rst);

	sequence frame_end_s;
		frame_ok ##0 (s.sh[FRAME_BITS-1:CMD_LSB] == CMD_SET_OUT);
	endsequence

	sequence fast_edge_s;
		at_fast != '0;
	endsequence

	sequence fast_off_s;
		((s.f_ovl & $past(at_fast)) == $past(at_fast)) && ((s.gate & $past(at_fast)) == '0);
	endsequence

	sequence slow_edge_s;
		at_slow != '0;
	endsequence

	sequence slow_off_s;
		((s.f_ovl & $past(at_slow)) == $past(at_slow)) && ((s.gate & $past(at_slow)) == '0);
	endsequence

	en_gate_a: assert property (!en_s |=> (s.gate == '0))
		else $error("stage on while enable low");

	fault_off_a: assert property ((s.gate & (s.f_ovl | s.f_otmp)) == '0)
		else $error("stage on with pending fault");

	ovl_hold_a: assert property ((s.f_ovl != '0) && !frame_ok && !avs_write
		|=> ((s.f_ovl & $past(s.f_ovl)) == $past(s.f_ovl)))
		else $error("overload flag lost without clear");

	fast_trip_a: assert property (fast_edge_s |=> fast_off_s)
		else $error("fast overload trip missed");

	slow_trip_a: assert property (slow_edge_s |=> slow_off_s)
		else $error("slow overload trip missed");

	cnt_bound_a: assert property (s.ovl_cnt[0] < SLOW_CYC)
		else $error("overload counter beyond limit");

	otmp_set_a: assert property (
		(ot_s != '0) |=> ((s.f_otmp & $past(ot_s)) == $past(ot_s)))
		else $error("overtemperature flag not set");

	par_route_a: assert property (en_s && !s.src_ser[0] && par_s[0]
		&& !next_s.f_ovl[0] && !next_s.f_otmp[0] |=> s.gate[0])
		else $error("parallel pin does not drive its channel");

	ser_take_a: assert property (frame_end_s |=> (s.ser_out == $past(s.sh[NCH-1:0])))
		else $error("serial output command not taken");

	chain_shift_a: assert property (
		!cs_n_s && !cs_fall && sclk_fall && (s.bit_cnt != '0)
		|=> (s.sh[0] == $past(s.si_bit)) && (s.sh[FRAME_BITS-1] == $past(s.sh[FRAME_BITS-2])))
		else $error("serial shift broken");

	bus_answer_a: assert property ((avs_read || avs_write) && s.wait_req |=> !s.wait_req)
		else $error("bus request not answered");

endmodule

//--- test/tcs_spi_host.sv
// Serial master model: frames the link and shifts words MSB first.
// Assumes mode 0 and a device that samples the link with its own clock.

`timescale 1ns/1ps

module tcs_spi_host (
	// Link
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si   = 1'b0;
	end

	// Clock stands still between frames; SI toggles once released
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = '0;
		spi_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_si = tx[i];
			#24 spi_sclk = 1'b1;
			rx = {rx[30:0], spi_so};
			#24 spi_sclk = 1'b0;
		end
		#24 spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#40;
	endtask
endmodule

//--- test/test_ten_channel_switch_control.sv
// Self-checking bench of the ten-channel switch control block.
// Assumes the serial master model and shortened overload counts.

`timescale 1ns/1ps

module test_ten_channel_switch_control;
	import tcs_pkg::*;
	localparam logic [CNT_W-1:0] SLOW = 9'h014;
	localparam logic [CNT_W-1:0] FAST = 9'h004;
	logic              clk, rst, dev_rst_n, en;
	logic              spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
	logic              avs_read, avs_write, avs_waitrequest, irq;
	logic [NCH-1:0]    par_in, stage_on, ovc_lo, ovc_hi, otmp, opn, sgnd, sbat;
	logic [NCH-1:0]    p, bk, bj;
	logic [NCH-1:0]    m [3];
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata, rd, rx;
	logic [15:0]       seed;
	int                n_fail, checks_done;

	tcs_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) tcs_top_i (
		.clk(clk), .rst(rst), .dev_rst_n(dev_rst_n), .en(en), .par_in(par_in),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n), .det_ovc_low(ovc_lo), .det_ovc_high(ovc_hi),
		.det_otmp(otmp), .det_open(opn), .det_sgnd(sgnd), .det_sbat(sbat),
		.stage_on(stage_on), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq)
	);

	tcs_spi_host tcs_spi_host_i (
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] on_exp(input logic [9:0] req, input logic [9:0] off);
		return en ? 32'(req & ~off) : 32'h0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic frame(input logic [31:0] tx, input int n);
		tcs_spi_host_i.xfer(tx, n, rx);
		@(posedge clk);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		finish_test();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{rst, dev_rst_n, en, par_in, ovc_lo, ovc_hi, otmp, opn, sgnd, sbat} = '1;
		{en, par_in, ovc_lo, ovc_hi, otmp, opn, sgnd, sbat} = '0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		seed = 16'hca58;
		n_fail = 0;
		checks_done = 0;
		cyc(16);
		rst <= 1'b0;
		cyc(6);
		chk(32'(stage_on), 32'h0);
		bus(1'b0, REG_SRC, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		en <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			par_in <= seed[9:0];
			cyc(6);
			chk(32'(stage_on), on_exp(par_in, 10'h0));
		end
		en <= 1'b0;
		seed = lfsr(seed);
		p = seed[9:0];
		frame({CMD_SET_SRC, 2'h0, 10'h3ff}, 16);
		frame({CMD_SET_OUT, 2'h0, p}, 16);
		chk(32'(stage_on), 32'h0);
		bus(1'b0, REG_SRC, 32'h0);
		chk(rd, 32'h3ff);
		en <= 1'b1;
		par_in <= ~p;
		cyc(6);
		chk(32'(stage_on), on_exp(p, 10'h0));
		frame({seed, CMD_NOP, 12'h0}, 32);
		chk(rx[15:0], seed);
		frame({CMD_SET_OUT, 2'h0, 10'h3ff}, 16);
		bk = 10'h1 << (seed % 10);
		bj = {bk[8:0], bk[9]};
		ovc_hi <= bk;
		ovc_lo <= bj;
		cyc(12);
		chk(32'(stage_on), on_exp(10'h3ff, bk));
		ovc_hi <= '0;
		cyc(16);
		chk(32'(stage_on), on_exp(10'h3ff, bk | bj));
		ovc_lo <= '0;
		cyc(20);
		chk(32'(stage_on), on_exp(10'h3ff, bk | bj));
		bus(1'b0, REG_FLT_OVL, 32'h0);
		chk(rd, 32'(bk | bj));
		bus(1'b1, REG_FLT_CLR, 32'(bk | bj));
		cyc(6);
		chk(32'(stage_on), on_exp(10'h3ff, 10'h0));
		otmp <= bj;
		cyc(8);
		chk(32'(stage_on), on_exp(10'h3ff, bj));
		otmp <= '0;
		cyc(20);
		bus(1'b0, REG_FLT_OTMP, 32'h0);
		chk(rd, 32'(bj));
		chk(32'(stage_on), on_exp(10'h3ff, bj));
		frame({CMD_CLEAR, 2'h0, bj}, 16);
		cyc(4);
		chk(32'(stage_on), on_exp(10'h3ff, 10'h0));
		chk(32'(irq), 32'h0);
		bus(1'b1, REG_SER_OUT, 32'(p));
		bus(1'b0, REG_STATE, 32'h0);
		chk(rd, (32'h1 << STATE_EN_BIT) | 32'(p));
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			m[i] = seed[9:0] | 10'h1;
		end
		opn <= m[0];
		sgnd <= m[1];
		sbat <= m[2];
		cyc(4);
		{opn, sgnd, sbat} <= '0;
		cyc(6);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, REG_FLT_OPEN + 8'(4 * i), 32'h0);
			chk(rd, 32'(m[i]));
		end
		fork
			frame({CMD_READ_DIAG, 9'h0, DSEL_SGND}, 16);
			begin
				cyc(10);
				chk(32'(spi_so_oe_n), 32'h0);
			end
		join
		chk(32'(spi_so_oe_n), 32'h1);
		frame({CMD_NOP, 12'h0}, 16);
		chk(rx[15:0], {DSEL_SGND, 3'h0, m[1]});
		bus(1'b1, REG_IRQ_MASK, 32'h1 << IRQ_OPEN);
		cyc(3);
		chk(32'(irq), 32'h1);
		bus(1'b1, REG_IRQ_STAT, 32'h1 << IRQ_OPEN);
		cyc(3);
		chk(32'(irq), 32'h0);
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk(rd & 32'h1c, 32'h18);
		frame({CMD_SET_OUT, 2'h0, 10'h3ff}, 16);
		dev_rst_n <= 1'b0;
		cyc(5);
		chk(32'(stage_on), 32'h0);
		dev_rst_n <= 1'b1;
		cyc(6);
		bus(1'b0, REG_SRC, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, REG_FLT_OPEN, 32'h0);
		chk(rd, 32'h0);
		chk(32'(stage_on), on_exp(par_in, 10'h0));
		finish_test();
	end
endmodule
